/* inc/tcm_pkg.sv */
// Constants, register map and carrier types for the timer counter block
package tcm_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int CNT_W = 16;
	// Register offsets
	localparam logic [2:0] OFS_GLB = 3'h0;
	localparam logic [2:0] OFS_CNT_H = 3'h1;
	localparam logic [2:0] OFS_CNT_L = 3'h2;
	localparam logic [2:0] OFS_MOD_H = 3'h3;
	localparam logic [2:0] OFS_MOD_L = 3'h4;
	localparam logic [2:0] OFS_CH_SC = 3'h5;
	localparam logic [2:0] OFS_CH_VH = 3'h6;
	localparam logic [2:0] OFS_CH_VL = 3'h7;
	// Global control/status fields
	localparam int GLB_OVF_BIT = 7;
	localparam int GLB_OIE_BIT = 6;
	localparam int GLB_CAS_BIT = 5;
	// Channel control/status fields
	localparam int CH_FLAG_BIT = 7;
	localparam int CH_IE_BIT = 6;
	localparam int CH_MSB_BIT = 5;
	localparam int CH_MSA_BIT = 4;
	localparam int CH_ELS_HI = 3;
	localparam int CH_ELS_LO = 2;
	// Edge/level select encodings
	localparam logic [1:0] ELS_OFF = 2'h0;
	localparam logic [1:0] ELS_01 = 2'h1;
	localparam logic [1:0] ELS_10 = 2'h2;
	localparam logic [1:0] ELS_11 = 2'h3;
	// Reset values and the full-range terminal count
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] MOD_RST = 16'h0000;
	localparam logic [15:0] VAL_RST = 16'h0000;
	localparam logic [15:0] FULL_TERM = 16'hFFFF;
	localparam logic [7:0] BYTE_RST = 8'h00;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tcm_bus_req_t;

	typedef struct packed {
		logic out;
		logic oe_n;
		logic release_gpio;
	} tcm_pin_out_t;

	typedef enum logic [1:0] {
		MODE_CAPTURE = 2'b00,
		MODE_COMPARE = 2'b01,
		MODE_EPWM = 2'b11,
		MODE_CPWM = 2'b10
	} tcm_mode_t;
endpackage : tcm_pkg

/* core/tcm_timer.sv */
// Timer counter with modulo, coherent byte access and one channel
//
// Operation
// - Reading either counter byte latches both until the other byte is read.
// - Reset, counter byte write or global register write releases the read latch.
// - Reset clears both counter bytes.
// - Debug halt freezes counter and read latch, even during counter reads.
// - At modulo value counter wraps to zero or turns down; overflow flag sets.
// - Writing one modulo byte inhibits overflow until the other byte is written.
// - Reset loads modulo zero, meaning free-run over the full range.
// - In capture mode an active pin edge sets the channel flag, bit 7.
// - In compare or edge PWM, counter equal to channel value sets the flag.
// - In center PWM every match, up or down, sets the flag.
// - Channel interrupt requested while flag and enable bit 6 both set.
// - Flag clears only after a read with flag set, then write of zero.
// - A new event during clearing restarts it; flag stays set.
// - Reset clears the flag; writing one to it does nothing.
// - Enable bit is read/write, reset clears it; zero disables requests.
// - Without center mode, mode bit B at bit 5 selects edge PWM.
// - Without center mode and B zero, mode bit A selects capture or compare.
// - Edge/level field bits 3:2 choose edge, compare action or PWM polarity.
// - Edge/level zero releases the pin to general-purpose use.
// - Capture edges: 01 rising, 10 falling, 11 both.
// - Compare actions: 00 none, 01 toggle, 10 clear, 11 set on match.
// - Edge PWM: 10 clears on match, X1 sets on match.
`timescale 1ns/1ps
module tcm_timer
	import tcm_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic timer_tick,
	input wire logic debug_halt,
	input wire tcm_bus_req_t bus_req,
	output logic [DATA_W-1:0] rdata,
	input wire logic ch_pin_in,
	output tcm_pin_out_t ch_pin,
	output logic ch_irq,
	output logic ovf_irq,
	output logic center_aligned_select
);

	function automatic tcm_mode_t tcm_decode(input logic cas, input logic msb, input logic msa);
		if (cas) begin
			return MODE_CPWM;
		end else if (msb) begin
			return MODE_EPWM;
		end else if (msa) begin
			return MODE_COMPARE;
		end
		return MODE_CAPTURE;
	endfunction : tcm_decode

	function automatic logic tcm_hit(input tcm_bus_req_t r, input logic [2:0] ofs);
		return r.addr == ofs;
	endfunction : tcm_hit

	logic [15:0] cnt_reg;
	logic dir_down_reg;
	logic [15:0] mod_reg;
	logic mod_pend_h_reg;
	logic mod_pend_l_reg;
	logic [15:0] latch_reg;
	logic latched_reg;
	logic first_hi_reg;
	logic ovf_flag_reg;
	logic ovf_armed_reg;
	logic oie_reg;
	logic cas_reg;
	logic ch_flag_reg;
	logic ch_armed_reg;
	logic ch_ie_reg;
	logic msb_reg;
	logic msa_reg;
	logic [1:0] els_reg;
	logic [15:0] ch_val_reg;
	logic [7:0] vbuf_h_reg;
	logic [7:0] vbuf_l_reg;
	logic vpend_h_reg;
	logic vpend_l_reg;
	logic pin_meta_reg;
	logic pin_sync_reg;
	logic pin_prev_reg;
	logic pin_out_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	logic wr_glb;
	logic wr_cnt;
	logic wr_mod_h;
	logic wr_mod_l;
	logic wr_sc;
	logic wr_vh;
	logic wr_vl;
	logic rd_cnt;
	logic rd_sc;
	logic rd_glb;
	logic tick;
	logic [15:0] term;
	logic at_term;
	logic mod_inhibit;
	logic ovf_event;
	logic cmp_match;
	logic rise;
	logic fall;
	logic cap_event;
	logic ch_event;
	tcm_mode_t mode;

	assign wr_glb = bus_req.wr && tcm_hit(bus_req, OFS_GLB);
	assign wr_cnt = bus_req.wr && (tcm_hit(bus_req, OFS_CNT_H) || tcm_hit(bus_req, OFS_CNT_L));
	assign wr_mod_h = bus_req.wr && tcm_hit(bus_req, OFS_MOD_H);
	assign wr_mod_l = bus_req.wr && tcm_hit(bus_req, OFS_MOD_L);
	assign wr_sc = bus_req.wr && tcm_hit(bus_req, OFS_CH_SC);
	assign wr_vh = bus_req.wr && tcm_hit(bus_req, OFS_CH_VH);
	assign wr_vl = bus_req.wr && tcm_hit(bus_req, OFS_CH_VL);
	assign rd_cnt = bus_req.rd && (tcm_hit(bus_req, OFS_CNT_H) || tcm_hit(bus_req, OFS_CNT_L));
	assign rd_sc = bus_req.rd && tcm_hit(bus_req, OFS_CH_SC);
	assign rd_glb = bus_req.rd && tcm_hit(bus_req, OFS_GLB);

	// Background mode suspends counting
	assign tick = timer_tick && !debug_halt;
	assign term = (mod_reg == MOD_RST) ? FULL_TERM : mod_reg;
	assign at_term = cnt_reg == term;
	assign mod_inhibit = mod_pend_h_reg || mod_pend_l_reg;
	// Center mode flags on leaving the terminal count downward
	assign ovf_event = tick && at_term && !(cas_reg && dir_down_reg) && !mod_inhibit;
	assign mode = tcm_decode(cas_reg, msb_reg, msa_reg);
	assign cmp_match = tick && (cnt_reg == ch_val_reg);
	assign rise = pin_sync_reg && !pin_prev_reg;
	assign fall = !pin_sync_reg && pin_prev_reg;
	always_comb begin
		cap_event = 1'b0;
		if (mode == MODE_CAPTURE) begin
			case (els_reg)
				ELS_01: cap_event = rise;
				ELS_10: cap_event = fall;
				ELS_11: cap_event = rise || fall;
				default: cap_event = 1'b0;
			endcase
		end
	end
	assign ch_event = (mode == MODE_CAPTURE) ? cap_event : cmp_match;

	// Pin synchroniser; edge logic reads only the second stage onward
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else if (clk_en) begin
			pin_meta_reg <= ch_pin_in;
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	// Main counter
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= CNT_RST;
			dir_down_reg <= 1'b0;
		end else if (clk_en) begin
			if (wr_cnt) begin
				cnt_reg <= CNT_RST;
				dir_down_reg <= 1'b0;
			end else if (tick) begin
				if (!cas_reg) begin
					dir_down_reg <= 1'b0;
					cnt_reg <= at_term ? CNT_RST : cnt_reg + 16'h0001;
				end else if (!dir_down_reg) begin
					if (at_term) begin
						dir_down_reg <= 1'b1;
						cnt_reg <= cnt_reg - 16'h0001;
					end else begin
						cnt_reg <= cnt_reg + 16'h0001;
					end
				end else if (cnt_reg == CNT_RST) begin
					dir_down_reg <= 1'b0;
					cnt_reg <= cnt_reg + 16'h0001;
				end else begin
					cnt_reg <= cnt_reg - 16'h0001;
				end
			end
		end
	end

	// Modulo bytes and the pairing that inhibits overflow
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mod_reg <= MOD_RST;
			mod_pend_h_reg <= 1'b0;
			mod_pend_l_reg <= 1'b0;
		end else if (clk_en) begin
			if (wr_mod_h) begin
				mod_reg[15:8] <= bus_req.wdata;
				mod_pend_h_reg <= !mod_pend_l_reg;
				mod_pend_l_reg <= 1'b0;
			end else if (wr_mod_l) begin
				mod_reg[7:0] <= bus_req.wdata;
				mod_pend_l_reg <= !mod_pend_h_reg;
				mod_pend_h_reg <= 1'b0;
			end
		end
	end

	// Counter read latch; frozen while halted so debugger reads leave it alone
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			latch_reg <= CNT_RST;
			latched_reg <= 1'b0;
			first_hi_reg <= 1'b0;
		end else if (clk_en) begin
			if (wr_cnt || wr_glb) begin
				latched_reg <= 1'b0;
			end else if (rd_cnt && !debug_halt) begin
				if (!latched_reg) begin
					latch_reg <= cnt_reg;
					latched_reg <= 1'b1;
					first_hi_reg <= tcm_hit(bus_req, OFS_CNT_H);
				end else if (tcm_hit(bus_req, OFS_CNT_H) != first_hi_reg) begin
					latched_reg <= 1'b0;
				end
			end
		end
	end

	// Global control and overflow flag
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ovf_flag_reg <= 1'b0;
			ovf_armed_reg <= 1'b0;
			oie_reg <= 1'b0;
			cas_reg <= 1'b0;
		end else if (clk_en) begin
			if (wr_glb) begin
				oie_reg <= bus_req.wdata[GLB_OIE_BIT];
				cas_reg <= bus_req.wdata[GLB_CAS_BIT];
			end
			// A fresh overflow wins over a pending clear
			if (ovf_event) begin
				ovf_flag_reg <= 1'b1;
				ovf_armed_reg <= 1'b0;
			end else if (wr_glb) begin
				if (ovf_armed_reg && !bus_req.wdata[GLB_OVF_BIT]) begin
					ovf_flag_reg <= 1'b0;
				end
				ovf_armed_reg <= 1'b0;
			end else if (rd_glb && ovf_flag_reg) begin
				ovf_armed_reg <= 1'b1;
			end
		end
	end

	// Channel control bits
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ch_ie_reg <= 1'b0;
			msb_reg <= 1'b0;
			msa_reg <= 1'b0;
			els_reg <= ELS_OFF;
		end else if (clk_en) begin
			if (wr_sc) begin
				ch_ie_reg <= bus_req.wdata[CH_IE_BIT];
				msb_reg <= bus_req.wdata[CH_MSB_BIT];
				msa_reg <= bus_req.wdata[CH_MSA_BIT];
				els_reg <= bus_req.wdata[CH_ELS_HI:CH_ELS_LO];
			end
		end
	end

	// Channel flag with read-then-write-zero clearing
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ch_flag_reg <= 1'b0;
			ch_armed_reg <= 1'b0;
		end else if (clk_en) begin
			if (ch_event) begin
				ch_flag_reg <= 1'b1;
				ch_armed_reg <= 1'b0;
			end else if (wr_sc) begin
				// Writing one is ignored
				if (ch_armed_reg && !bus_req.wdata[CH_FLAG_BIT]) begin
					ch_flag_reg <= 1'b0;
				end
				ch_armed_reg <= 1'b0;
			end else if (rd_sc && ch_flag_reg) begin
				ch_armed_reg <= 1'b1;
			end
		end
	end

	// Channel value with buffered paired writes; capture takes priority
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ch_val_reg <= VAL_RST;
			vbuf_h_reg <= BYTE_RST;
			vbuf_l_reg <= BYTE_RST;
			vpend_h_reg <= 1'b0;
			vpend_l_reg <= 1'b0;
		end else if (clk_en) begin
			if (cap_event) begin
				ch_val_reg <= cnt_reg;
			end else if (wr_vh && vpend_l_reg) begin
				ch_val_reg <= {bus_req.wdata, vbuf_l_reg};
			end else if (wr_vl && vpend_h_reg) begin
				ch_val_reg <= {vbuf_h_reg, bus_req.wdata};
			end
			if (wr_sc) begin
				vpend_h_reg <= 1'b0;
				vpend_l_reg <= 1'b0;
			end else if (wr_vh) begin
				vbuf_h_reg <= bus_req.wdata;
				vpend_h_reg <= !vpend_l_reg;
				vpend_l_reg <= 1'b0;
			end else if (wr_vl) begin
				vbuf_l_reg <= bus_req.wdata;
				vpend_l_reg <= !vpend_h_reg;
				vpend_h_reg <= 1'b0;
			end
		end
	end

	// Channel output pin
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_out_reg <= 1'b0;
		end else if (clk_en && els_reg != ELS_OFF) begin
			case (mode)
				MODE_COMPARE: begin
					if (cmp_match) begin
						case (els_reg)
							ELS_01: pin_out_reg <= !pin_out_reg;
							ELS_10: pin_out_reg <= 1'b0;
							ELS_11: pin_out_reg <= 1'b1;
							default: pin_out_reg <= pin_out_reg;
						endcase
					end
				end
				MODE_EPWM: begin
					// Match beats period start when value equals terminal count
					if (cmp_match) begin
						pin_out_reg <= els_reg[0];
					end else if (tick && at_term) begin
						pin_out_reg <= !els_reg[0];
					end
				end
				MODE_CPWM: begin
					if (cmp_match) begin
						pin_out_reg <= els_reg[0] ^ dir_down_reg;
					end
				end
				default: pin_out_reg <= pin_out_reg;
			endcase
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_comb begin
		rdata_next = BYTE_RST;
		if (bus_req.rd) begin
			case (bus_req.addr)
				OFS_GLB: rdata_next = {ovf_flag_reg, oie_reg, cas_reg, 5'h00};
				OFS_CNT_H: rdata_next = latched_reg ? latch_reg[15:8] : cnt_reg[15:8];
				OFS_CNT_L: rdata_next = latched_reg ? latch_reg[7:0] : cnt_reg[7:0];
				OFS_MOD_H: rdata_next = mod_reg[15:8];
				OFS_MOD_L: rdata_next = mod_reg[7:0];
				OFS_CH_SC: rdata_next = {ch_flag_reg, ch_ie_reg, msb_reg, msa_reg, els_reg, 2'h0};
				OFS_CH_VH: rdata_next = ch_val_reg[15:8];
				OFS_CH_VL: rdata_next = ch_val_reg[7:0];
				default: rdata_next = BYTE_RST;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rdata_reg <= BYTE_RST;
		end else if (clk_en) begin
			rdata_reg <= rdata_next;
		end
	end

	assign rdata = rdata_reg;
	assign ch_irq = ch_flag_reg && ch_ie_reg;
	assign ovf_irq = ovf_flag_reg && oie_reg;
	assign center_aligned_select = cas_reg;
	assign ch_pin.out = pin_out_reg;
	// Capture mode and released pin never drive
	assign ch_pin.oe_n = (els_reg == ELS_OFF) || (mode == MODE_CAPTURE);
	assign ch_pin.release_gpio = els_reg == ELS_OFF;

endmodule : tcm_timer

/* dv/tcm_timer_chk.sv */
// Port-level assertions for the timer counter block
`timescale 1ns/1ps
module tcm_timer_chk
	import tcm_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic timer_tick,
	input wire logic debug_halt,
	input wire tcm_bus_req_t bus_req,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic ch_pin_in,
	input wire tcm_pin_out_t ch_pin,
	input wire logic ch_irq,
	input wire logic ovf_irq,
	input wire logic center_aligned_select
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	wire logic rd_at = bus_req.rd && clk_en;
	wire logic wr_at = bus_req.wr && clk_en;
	wire logic sc_wr = wr_at && bus_req.addr == OFS_CH_SC;
	a_reset_out_idle: assert property ($rose(reset_n) |-> rdata == 8'h00 && !ch_irq && ch_pin.release_gpio)
		else $error("outputs not idle after reset");
	a_read_data_slot: assert property (!$past(rd_at) |-> rdata == 8'h00)
		else $error("read data outside its slot");
	a_gpio_release: assert property (sc_wr |=> ch_pin.release_gpio == ($past(bus_req.wdata[3:2]) == ELS_OFF))
		else $error("pin release does not follow edge select");
	a_release_no_drive: assert property (ch_pin.release_gpio |-> ch_pin.oe_n)
		else $error("released pin still driven");
	a_irq_gate_off: assert property (sc_wr && !bus_req.wdata[CH_IE_BIT] |=> !ch_irq)
		else $error("channel request with enable cleared");
	a_center_sel_out: assert property (wr_at && bus_req.addr == OFS_GLB |=> center_aligned_select == $past(bus_req.wdata[GLB_CAS_BIT]))
		else $error("center select not taken from write");
	a_debug_frozen: assert property ((rd_at && debug_halt && bus_req.addr == OFS_CNT_H) ##1 debug_halt ##1 (rd_at && debug_halt && bus_req.addr == OFS_CNT_H) |=> rdata == $past(rdata, 2))
		else $error("counter moved during debug halt");
	a_cnt_restart: assert property ((wr_at && bus_req.addr == OFS_CNT_L && !timer_tick) ##1 !timer_tick ##1 (rd_at && bus_req.addr == OFS_CNT_H) |=> rdata == 8'h00)
		else $error("counter write did not restart counter");
	c_flag_clear: cover property ((rd_at && bus_req.addr == OFS_CH_SC) ##2 sc_wr);
	c_irq_rise: cover property ($rose(ch_irq));
	c_debug_read: cover property (rd_at && debug_halt);
endmodule : tcm_timer_chk
bind tcm_timer tcm_timer_chk chk_u (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
	.timer_tick(timer_tick), .debug_halt(debug_halt), .bus_req(bus_req), .rdata(rdata),
	.ch_pin_in(ch_pin_in), .ch_pin(ch_pin), .ch_irq(ch_irq), .ovf_irq(ovf_irq),
	.center_aligned_select(center_aligned_select));

/* dv/tcm_timer_tb_top.sv */
// Self-checking bench for the timer counter block
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module tcm_timer_tb_top
	import tcm_pkg::*;
;
	logic clock, reset_n, clk_en, timer_tick, debug_halt, ch_pin_in, ch_irq, ovf_irq, cas;
	tcm_bus_req_t bus_req;
	logic [7:0] rdata;
	tcm_pin_out_t ch_pin;
	int error_cnt = 0;
	int n_compared = 0;
	tcm_timer dut_u (.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .timer_tick(timer_tick),
		.debug_halt(debug_halt), .bus_req(bus_req), .rdata(rdata), .ch_pin_in(ch_pin_in),
		.ch_pin(ch_pin), .ch_irq(ch_irq), .ovf_irq(ovf_irq), .center_aligned_select(cas));
	task automatic complete_run();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clock);
		bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus_req <= '0;
		// Past the edge, so callers see what the write updated
		#1;
	endtask : wr
	// Masked read; rdata stands only in the cycle after the strobe
	task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clock);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus_req <= '0;
		#1;
		`CHK(rdata & m, e)
	endtask : rc
	task automatic clr(input logic [7:0] v);
		rc(OFS_CH_SC, 8'h7F, v & 8'h7F);
		wr(OFS_CH_SC, v);
	endtask : clr
	// Exactly n ticks, then settle time for registered outputs
	task automatic ticks(input int n);
		@(posedge clock);
		timer_tick <= 1'b1;
		repeat (n) @(posedge clock);
		timer_tick <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask : ticks
	task automatic pin(input logic v);
		@(posedge clock);
		ch_pin_in <= v;
		repeat (6) @(posedge clock);
	endtask : pin
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		complete_run();
	end
	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		timer_tick = 1'b0;
		debug_halt = 1'b0;
		ch_pin_in = 1'b0;
		bus_req = '0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		rc(OFS_MOD_H, 8'hFF, 8'h00);
		rc(OFS_MOD_L, 8'hFF, 8'h00);
		rc(OFS_CH_SC, 8'hFF, 8'h00);
		rc(OFS_CNT_L, 8'hFF, 8'h00);
		rc(OFS_CNT_H, 8'hFF, 8'h00);
		wr(OFS_CNT_L, 8'hA5);
		rc(OFS_CNT_H, 8'hFF, 8'h00);
		ticks(300);
		rc(OFS_CNT_L, 8'hFF, 8'h00);
		rc(OFS_CNT_H, 8'hFF, 8'h01);
		ticks(100);
		rc(OFS_CNT_L, 8'hFF, 8'h2C);
		rc(OFS_CNT_H, 8'hFF, 8'h01);
		ticks(4);
		wr(OFS_GLB, 8'h00);
		rc(OFS_CNT_L, 8'hFF, 8'h94);
		rc(OFS_CNT_H, 8'hFF, 8'h01);
		// Halt entered unlatched, so a read that latched would show later
		@(posedge clock);
		debug_halt <= 1'b1;
		ticks(10);
		rc(OFS_CNT_H, 8'hFF, 8'h01);
		rc(OFS_CNT_H, 8'hFF, 8'h01);
		@(posedge clock);
		debug_halt <= 1'b0;
		ticks(4);
		rc(OFS_CNT_L, 8'hFF, 8'h98);
		rc(OFS_CNT_H, 8'hFF, 8'h01);
		// Counter zeroed before the modulo is written, so the first wrap is known
		wr(OFS_GLB, 8'h40);
		wr(OFS_CNT_L, 8'h00);
		wr(OFS_MOD_H, 8'h00);
		wr(OFS_MOD_L, 8'h05);
		ticks(6);
		rc(OFS_GLB, 8'h80, 8'h80);
		`CHK(ovf_irq, 1'b1)
		rc(OFS_CNT_L, 8'hFF, 8'h00);
		wr(OFS_GLB, 8'h40);
		wr(OFS_MOD_H, 8'h00);
		ticks(6);
		rc(OFS_GLB, 8'h80, 8'h00);
		wr(OFS_MOD_L, 8'h05);
		ticks(6);
		rc(OFS_GLB, 8'h80, 8'h80);
		wr(OFS_GLB, 8'h00);
		wr(OFS_CH_SC, 8'h54);
		wr(OFS_CH_VH, 8'h00);
		wr(OFS_CH_VL, 8'h03);
		ticks(4);
		rc(OFS_CH_SC, 8'hFF, 8'hD4);
		`CHK(ch_irq, 1'b1)
		`CHK({ch_pin.out, ch_pin.oe_n}, 2'b10)
		wr(OFS_CH_SC, 8'h54);
		rc(OFS_CH_SC, 8'hFF, 8'h54);
		`CHK(ch_irq, 1'b0)
		wr(OFS_CH_SC, 8'hD4);
		rc(OFS_CH_SC, 8'hFF, 8'h54);
		ticks(6);
		wr(OFS_CH_SC, 8'h54);
		rc(OFS_CH_SC, 8'hFF, 8'hD4);
		ticks(6);
		wr(OFS_CH_SC, 8'h54);
		rc(OFS_CH_SC, 8'hFF, 8'hD4);
		wr(OFS_CH_SC, 8'h28);
		ticks(6);
		`CHK(ch_pin.out, 1'b0)
		ticks(2);
		`CHK(ch_pin.out, 1'b1)
		wr(OFS_GLB, 8'h20);
		wr(OFS_CNT_L, 8'h00);
		clr(8'h28);
		ticks(5);
		rc(OFS_CH_SC, 8'h80, 8'h80);
		wr(OFS_CH_SC, 8'h28);
		rc(OFS_CH_SC, 8'h80, 8'h00);
		ticks(5);
		rc(OFS_CH_SC, 8'h80, 8'h80);
		wr(OFS_GLB, 8'h00);
		wr(OFS_CH_SC, 8'h00);
		`CHK({ch_pin.release_gpio, ch_pin.oe_n}, 2'b11)
		wr(OFS_CNT_L, 8'h00);
		ticks(2);
		for (int e = 1; e < 4; e++) begin
			wr(OFS_CH_SC, 8'(e << 2));
			clr(8'(e << 2));
			pin(1'b1);
			rc(OFS_CH_SC, 8'h80, e[0] ? 8'h80 : 8'h00);
			clr(8'(e << 2));
			pin(1'b0);
			rc(OFS_CH_SC, 8'h80, e[1] ? 8'h80 : 8'h00);
		end
		rc(OFS_CH_VL, 8'hFF, 8'h02);
		rc(OFS_CH_VH, 8'hFF, 8'h00);
		complete_run();
	end
endmodule : tcm_timer_tb_top
